// [dv/dual_digipot_i2c_slave_properties.sv]
// Port-level checker for the digipot slave.
// Assumes the bench keeps each clock phase well above the synchroniser delay.
`timescale 1ns/1ns
module dual_digipot_i2c_slave_properties (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_o,
    // Resistor state
    input wire digipot_pkg::channel_drive_t chan1_drive_o,
    input wire digipot_pkg::channel_drive_t chan2_drive_o,
    input wire logic [digipot_pkg::CODE_W-1:0] chan1_code_o,
    input wire logic [digipot_pkg::CODE_W-1:0] chan2_code_o,
    input wire logic shutdown_flag_o,
    input wire logic channel_select_bit_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    tap_decode_a: assert property (!shutdown_flag_o |=>
        chan1_drive_o.tap_onehot == (256'h1 << $past(chan1_code_o)) && !chan1_drive_o.top_open)
        else $error("chan1 tap does not follow its code");
    shutdown_drive_a: assert property (shutdown_flag_o |=> chan2_drive_o.top_open &&
        chan2_drive_o.wiper_to_bottom && chan2_drive_o.tap_onehot == '0)
        else $error("chan2 not isolated in shutdown");
    chan_isolate_a: assert property ($changed(chan1_code_o) |-> $stable(chan2_code_o))
        else $error("both codes changed together");
    ch1_select_a: assert property ($changed(chan1_code_o) |-> !channel_select_bit_o)
        else $error("chan1 written while chan2 selected");
    ch2_select_a: assert property ($changed(chan2_code_o) |-> channel_select_bit_o)
        else $error("chan2 written while chan1 selected");
    code_low_a: assert property ($changed(chan1_code_o) || $changed(chan2_code_o) |-> !scl_i)
        else $error("code stored outside clock low phase");
    sd_keeps_a: assert property ($changed(shutdown_flag_o) |->
        $stable(chan1_code_o) && $stable(chan2_code_o))
        else $error("shutdown change altered a code");
    oe_low_clk_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive moved while clock high");
    start_quiet_a: assert property (scl_i && $fell(sda_i) |=> !sda_oe_o [*8])
        else $error("data driven right after start");
    cover property ($rose(shutdown_flag_o));
    cover property ($changed(chan2_code_o));
    cover property (sda_oe_o && scl_i && channel_select_bit_o);
endmodule
bind dual_digipot_i2c_slave dual_digipot_i2c_slave_properties props (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_oe_o(sda_oe_o), .chan1_drive_o(chan1_drive_o), .chan2_drive_o(chan2_drive_o),
    .chan1_code_o(chan1_code_o), .chan2_code_o(chan2_code_o),
    .shutdown_flag_o(shutdown_flag_o), .channel_select_bit_o(channel_select_bit_o)
);

// [dv/dual_digipot_i2c_slave_tb_top.sv]
// Self-checking bench for the digipot slave, one task per scenario.
// Assumes the master model and a pulled-up data wire; checker is bound in.
`timescale 1ns/1ns
module dual_digipot_i2c_slave_tb_top;
    localparam logic [6:0] ADR = {digipot_pkg::ADDR_FIXED_HI, digipot_pkg::ADDR_FIXED_LO};
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic fixed_addr_variant_i = 1'b1;
    logic [1:0] strap = 2'b00;
    logic scl, msda, sda_o, sda_oe_o, sd, sel;
    logic [7:0] c1, c2;
    digipot_pkg::channel_drive_t d1, d2;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    // Open drain: either party pulling low wins, else the pull-up
    wire logic sda = msda & ~sda_oe_o;
    i2c_master_model m (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(msda));
    dual_digipot_i2c_slave dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .fixed_addr_variant_i(fixed_addr_variant_i),
        .strap_addr_bit_low_i(strap[0]), .strap_addr_bit_high_i(strap[1]),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .chan1_drive_o(d1), .chan2_drive_o(d2), .chan1_code_o(c1), .chan2_code_o(c2),
        .shutdown_flag_o(sd), .channel_select_bit_o(sel)
    );
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tap(input digipot_pkg::channel_drive_t d, input logic [7:0] c, input logic s);
        logic [255:0] e;
        e = s ? 256'h0 : 256'h1 << c;
        chk({6'h0, d.top_open, d.wiper_to_bottom}, {6'h0, s, s});
        chk({7'h0, d.tap_onehot === e}, 8'h01);
    endtask
    task automatic wr(input logic [6:0] adr, input logic [7:0] ins, input logic [7:0] d0,
                      input logic [7:0] d1x, input int nd, input logic ak_exp);
        logic [7:0] rx;
        logic ak;
        m.start();
        m.xfer({adr, 1'b0}, 1'b1, rx, ak);
        chk({7'h0, ak}, {7'h0, ak_exp});
        m.xfer(ins, 1'b1, rx, ak);
        if (nd > 0) m.xfer(d0, 1'b1, rx, ak);
        if (nd > 1) m.xfer(d1x, 1'b1, rx, ak);
        chk({7'h0, ak}, {7'h0, ak_exp});
        m.stop();
    endtask
    task automatic s_reset();
        chk(c1, digipot_pkg::MIDSCALE_CODE);
        chk(c2, digipot_pkg::MIDSCALE_CODE);
        chk({5'h0, sd, sda_o, sda_oe_o}, 8'h00);
        tap(d1, 8'h80, 1'b0);
    endtask
    task automatic s_channels();
        wr(ADR, 8'h3f, 8'h3c, 8'h00, 1, 1'b0);
        wr(ADR, 8'h80, 8'hc5, 8'h00, 1, 1'b0);
        chk(c1, 8'h3c);
        chk(c2, 8'hc5);
        tap(d2, 8'hc5, 1'b0);
    endtask
    task automatic s_repeat();
        wr(ADR, 8'h00, 8'h00, 8'hff, 2, 1'b0);
        chk(c1, 8'hff);
        chk(c2, 8'hc5);
        tap(d1, 8'hff, 1'b0);
    endtask
    task automatic s_shutdown();
        m.hp = 20;
        wr(ADR, 8'hc0, 8'h22, 8'h00, 1, 1'b0);
        chk({6'h0, sd, sel}, 8'h03);
        chk(c1, 8'hff);
        chk(c2, 8'h22);
        tap(d1, 8'hff, 1'b1);
        wr(ADR, 8'h00, 8'h00, 8'h00, 0, 1'b0);
        tap(d1, 8'hff, 1'b0);
        tap(d2, 8'h22, 1'b0);
        m.hp = 10;
    endtask
    task automatic s_read();
        logic [7:0] rx;
        logic ak;
        wr(ADR, 8'h80, 8'h00, 8'h00, 0, 1'b0);
        m.start();
        m.xfer({ADR, 1'b1}, 1'b1, rx, ak);
        chk({7'h0, ak}, 8'h00);
        m.xfer(8'hff, 1'b0, rx, ak);
        chk(rx, 8'h22);
        m.xfer(8'hff, 1'b1, rx, ak);
        chk(rx, 8'h22);
        m.stop();
    endtask
    task automatic s_address();
        wr(ADR ^ 7'h01, 8'h00, 8'h55, 8'h00, 1, 1'b1);
        chk(c1, 8'hff);
        fixed_addr_variant_i <= 1'b0;
        strap <= 2'b01;
        wr(ADR, 8'h00, 8'h66, 8'h00, 1, 1'b1);
        wr({digipot_pkg::ADDR_FIXED_HI, 2'b01}, 8'h00, 8'h77, 8'h00, 1, 1'b0);
        chk(c1, 8'h77);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        s_reset();
        s_channels();
        s_repeat();
        s_shutdown();
        s_read();
        s_address();
        end_of_test();
    end
endmodule

// [dv/i2c_master_model.sv]
// Bus master model for the two-wire port of the digipot slave.
// Assumes the bench resolves the data wire with a pull-up and feeds it back here.
`timescale 1ns/1ns
module i2c_master_model (
    // Clock
    input wire logic clk_sys_i,
    // Bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Half phase in system clocks; the bench raises it for a slow master
    int hp = 10;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt();
        repeat (hp) @(posedge clk_sys_i);
    endtask
    // Data moves only a half phase after the clock fell, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        wt();
        scl_o <= 1'b1;
        wt();
        r = sda_i;
        scl_o <= 1'b0;
        wt();
    endtask
    task automatic start();
        sda_o <= 1'b1;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_o <= 1'b0;
        wt();
        scl_o <= 1'b0;
        wt();
    endtask
    task automatic stop();
        sda_o <= 1'b0;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_o <= 1'b1;
        wt();
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(mack, ak);
    endtask
endmodule

// [src/digipot_pkg.sv]
// Constants and carrier types for the dual digital potentiometer serial slave.
// Assumes one 20 MHz system clock; bus pins arrive asynchronously.
//
// Summary of operation
// - First byte is address plus direction bit.
// - Fixed address or two strapped address bits.
// - Matching address is acknowledged on ninth clock.
// - Mismatch leaves data line undriven until done.
// - Direction high reads, low writes.
// - Byte after write address is the instruction.
// - Instruction MSB selects channel one or two.
// - Shutdown bit opens top, wiper to bottom.
// - Shutdown keeps codes; release reapplies them.
// - Codes still written during shutdown.
// - Six low instruction bits are ignored.
// - Data byte MSB first, acknowledged, stored.
// - Code decodes to one of 256 taps.
// - Power-on presets both codes to midscale.
// - Read returns last selected channel's code.
// - Further write data bytes update code again.
package digipot_pkg;

    localparam int CODE_W = 8;
    localparam int TAP_N = 256;
    localparam logic [CODE_W-1:0] MIDSCALE_CODE = 8'h80;
    // Upper five address bits are common to both variants
    localparam logic [4:0] ADDR_FIXED_HI = 5'h0b;
    localparam logic [1:0] ADDR_FIXED_LO = 2'h3;
    localparam int INSTR_CHAN_BIT = 7;
    localparam int INSTR_SD_BIT = 6;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INSTR,
        ST_DATA,
        ST_READ,
        ST_IGNORE
    } bus_state_t;

    // Analog switch control for one channel
    typedef struct packed {
        logic top_open;
        logic wiper_to_bottom;
        logic [TAP_N-1:0] tap_onehot;
    } channel_drive_t;

endpackage

// [src/dual_digipot_i2c_slave.sv]
// Serial slave, two wiper code latches and their tap decoders.
// Assumes open-drain data line resolved outside; scl_i and sda_i are raw pins.
`timescale 1ns/1ns
module dual_digipot_i2c_slave (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Variant and strap pins
    input wire logic fixed_addr_variant_i,
    input wire logic strap_addr_bit_low_i,
    input wire logic strap_addr_bit_high_i,
    // Two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Resistor controls and status
    output digipot_pkg::channel_drive_t chan1_drive_o,
    output digipot_pkg::channel_drive_t chan2_drive_o,
    output logic [digipot_pkg::CODE_W-1:0] chan1_code_o,
    output logic [digipot_pkg::CODE_W-1:0] chan2_code_o,
    output logic shutdown_flag_o,
    output logic channel_select_bit_o
);

    // ==========================================================
    // Functions
    function automatic logic [digipot_pkg::TAP_N-1:0] tap_decode(
        input logic [digipot_pkg::CODE_W-1:0] code
    );
        logic [digipot_pkg::TAP_N-1:0] taps;
        taps = '0;
        taps[code] = 1'b1;
        return taps;
    endfunction

    function automatic digipot_pkg::channel_drive_t drive_of(
        input logic [digipot_pkg::CODE_W-1:0] code,
        input logic sd
    );
        digipot_pkg::channel_drive_t d;
        d.top_open = sd;
        d.wiper_to_bottom = sd;
        // Tap follows the stored code again once shutdown clears
        d.tap_onehot = sd ? '0 : tap_decode(code);
        return d;
    endfunction

    // ==========================================================
    // Pin synchronisers: three stages, change taken when stages two and three agree
    logic [2:0] scl_sync, sda_sync, next_scl_sync, next_sda_sync;
    logic scl_f, sda_f, next_scl_f, next_sda_f;
    // Address choice pins: bit 2 variant, bits 1..0 straps; filtered bit by bit
    logic [2:0] strap_pins, strap_s1, strap_s2, strap_s3, strap_f, next_strap_f;

    assign strap_pins = {fixed_addr_variant_i, strap_addr_bit_high_i, strap_addr_bit_low_i};

    always_comb begin
        next_scl_sync = {scl_sync[1:0], scl_i};
        next_sda_sync = {sda_sync[1:0], sda_i};
        next_scl_f = (scl_sync[2] == scl_sync[1]) ? scl_sync[2] : scl_f;
        next_sda_f = (sda_sync[2] == sda_sync[1]) ? sda_sync[2] : sda_f;
        next_strap_f = (strap_s3 & ~(strap_s3 ^ strap_s2)) | (strap_f & (strap_s3 ^ strap_s2));
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            strap_s1 <= '0;
            strap_s2 <= '0;
            strap_s3 <= '0;
            strap_f <= '0;
        end else begin
            scl_sync <= next_scl_sync;
            sda_sync <= next_sda_sync;
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            strap_s1 <= strap_pins;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            strap_f <= next_strap_f;
        end
    end

    // ==========================================================
    // Bus events
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_ev, stop_ev;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign start_ev = scl_f && scl_q && sda_q && !sda_f;
    assign stop_ev = scl_f && scl_q && !sda_q && sda_f;

    // ==========================================================
    // Own address, from the filtered strap levels
    logic [6:0] own_addr;
    always_comb begin
        own_addr = {digipot_pkg::ADDR_FIXED_HI, digipot_pkg::ADDR_FIXED_LO};
        if (!strap_f[2]) begin
            own_addr[1:0] = strap_f[1:0];
        end
    end

    // ==========================================================
    // Protocol engine
    digipot_pkg::bus_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic ack_drive, next_ack_drive;
    logic tx_drive, next_tx_drive;
    logic [digipot_pkg::CODE_W-1:0] code1, code2, next_code1, next_code2;
    logic chan_sel, next_chan_sel, sd_flag, next_sd_flag;
    logic sent_bit, next_sent_bit;
    logic read_go, next_read_go;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_ack_drive = ack_drive;
        next_tx_drive = tx_drive;
        next_code1 = code1;
        next_code2 = code2;
        next_chan_sel = chan_sel;
        next_sd_flag = sd_flag;
        next_sent_bit = sent_bit;
        next_read_go = read_go;
        if (start_ev) begin
            next_state = digipot_pkg::ST_ADDR;
            // The clock fall that closes the start wraps this to bit zero
            next_bit_cnt = '1;
            next_ack_drive = 1'b0;
            next_tx_drive = 1'b0;
        end else if (stop_ev) begin
            next_state = digipot_pkg::ST_IDLE;
            next_ack_drive = 1'b0;
            next_tx_drive = 1'b0;
        end else begin
            case (state)
                digipot_pkg::ST_IDLE, digipot_pkg::ST_IGNORE: begin
                    next_ack_drive = 1'b0;
                    next_tx_drive = 1'b0;
                end
                digipot_pkg::ST_ADDR, digipot_pkg::ST_INSTR, digipot_pkg::ST_DATA: begin
                    if (scl_rise && bit_cnt <= digipot_pkg::LAST_BIT) begin
                        next_shreg = {shreg[6:0], sda_f};
                    end
                    if (scl_fall) begin
                        if (bit_cnt == digipot_pkg::LAST_BIT) begin
                            next_bit_cnt = digipot_pkg::ACK_BIT;
                            if (state == digipot_pkg::ST_ADDR) begin
                                if (shreg[7:1] == own_addr) begin
                                    next_ack_drive = 1'b1;
                                end else begin
                                    next_state = digipot_pkg::ST_IGNORE;
                                end
                            end else begin
                                next_ack_drive = 1'b1;
                                if (state == digipot_pkg::ST_INSTR) begin
                                    next_chan_sel = shreg[digipot_pkg::INSTR_CHAN_BIT];
                                    next_sd_flag = shreg[digipot_pkg::INSTR_SD_BIT];
                                end else if (!chan_sel) begin
                                    next_code1 = shreg;
                                end else begin
                                    next_code2 = shreg;
                                end
                            end
                        end else if (bit_cnt == digipot_pkg::ACK_BIT) begin
                            next_ack_drive = 1'b0;
                            next_bit_cnt = '0;
                            if (state == digipot_pkg::ST_ADDR) begin
                                // Direction bit sits in the low bit of the address byte
                                if (shreg[0]) begin
                                    next_state = digipot_pkg::ST_READ;
                                    next_shreg = chan_sel ? code2 : code1;
                                    next_read_go = 1'b1;
                                end else begin
                                    next_state = digipot_pkg::ST_INSTR;
                                end
                            end else begin
                                next_state = digipot_pkg::ST_DATA;
                            end
                        end else begin
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                digipot_pkg::ST_READ: begin
                    // Bits 0..7 go out, count 8 samples the master's acknowledge
                    if (read_go) begin
                        next_tx_drive = !shreg[7];
                        next_sent_bit = shreg[7];
                        next_shreg = {shreg[6:0], 1'b0};
                        next_read_go = 1'b0;
                    end else if (scl_fall) begin
                        if (bit_cnt == digipot_pkg::LAST_BIT) begin
                            next_tx_drive = 1'b0;
                            next_bit_cnt = digipot_pkg::ACK_BIT;
                        end else if (bit_cnt == digipot_pkg::ACK_BIT) begin
                            next_bit_cnt = '0;
                            next_shreg = chan_sel ? code2 : code1;
                            next_read_go = 1'b1;
                        end else begin
                            next_bit_cnt = bit_cnt + 4'h1;
                            next_tx_drive = !shreg[7];
                            next_sent_bit = shreg[7];
                            next_shreg = {shreg[6:0], 1'b0};
                        end
                    end else if (scl_rise && bit_cnt == digipot_pkg::ACK_BIT && sda_f) begin
                        // No acknowledge: stay off the line until stop or start
                        next_state = digipot_pkg::ST_IGNORE;
                    end
                end
                default: begin
                    next_state = digipot_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= digipot_pkg::ST_IDLE;
            bit_cnt <= '0;
            shreg <= '0;
            ack_drive <= 1'b0;
            tx_drive <= 1'b0;
            code1 <= digipot_pkg::MIDSCALE_CODE;
            code2 <= digipot_pkg::MIDSCALE_CODE;
            chan_sel <= 1'b0;
            sd_flag <= 1'b0;
            sent_bit <= 1'b1;
            read_go <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            ack_drive <= next_ack_drive;
            tx_drive <= next_tx_drive;
            code1 <= next_code1;
            code2 <= next_code2;
            chan_sel <= next_chan_sel;
            sd_flag <= next_sd_flag;
            sent_bit <= next_sent_bit;
            read_go <= next_read_go;
        end
    end

    // ==========================================================
    // Outputs
    assign sda_o = 1'b0;
    assign sda_oe_o = ack_drive || tx_drive;
    assign chan1_code_o = code1;
    assign chan2_code_o = code2;
    assign shutdown_flag_o = sd_flag;
    assign channel_select_bit_o = chan_sel;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            chan1_drive_o <= drive_of(digipot_pkg::MIDSCALE_CODE, 1'b0);
            chan2_drive_o <= drive_of(digipot_pkg::MIDSCALE_CODE, 1'b0);
        end else begin
            chan1_drive_o <= drive_of(code1, sd_flag);
            chan2_drive_o <= drive_of(code2, sd_flag);
        end
    end

endmodule
